//--- rtl/cag_cfg.svh
// constants for the address generator and processing-state control
// Contract
// - displacement added to address register; 16-bit form sign-extended.
// - post-increment uses register as address, then adds 1, 2 or 4.
// - pre-decrement subtracts 1, 2 or 4 first, uses and writes back result.
// - 8-bit absolute address fills upper bits with ones, top 256 bytes.
// - 16-bit absolute address is sign-extended to full width.
// - 32-bit absolute address is used directly, reaching whole space.
// - 24-bit absolute is program address only, upper eight bits zero; the code also accepts it for data operands.
// - immediate operands come from instruction in 8, 16 or 32 bits.
// - bit number from 3-bit field; trap vector from 2-bit field.
// - sign-extended displacement plus 24-bit counter, low 24 bits kept.
// - relative branch base is the next instruction's first byte address.
// - memory-indirect 8-bit address is zero-extended, range 0 to 255.
// - memory-indirect operand is longword, first byte taken as zero.
// - word, longword or branch target at odd address clears bit zero.
// - reset low stops processing, enters reset state, masks all interrupts.
// - reset exception handling begins when reset goes high again.
// - watchdog overflow also enters the reset state.
// - exception fetches start address from vector table and branches there.
// - other master's bus request releases bus and halts CPU until returned.
// - sleep or hardware standby enters program stop state; CPU ceases.
// - bit set/clear/invert/store ops read a byte, modify, write it back.
`ifndef CAG_CFG_SVH
`define CAG_CFG_SVH
`define CAG_STEP_BYTE 32'h00000001
`define CAG_STEP_WORD 32'h00000002
`define CAG_STEP_LONG 32'h00000004
`define CAG_ABS8_FILL 16'hFFFF
`define CAG_IND_HI 16'h0000
`define CAG_ALIGN_MASK 24'hFFFFFE
`define CAG_RESET_VEC 8'h00
`define CAG_TRAP_VEC_BASE 8'h08
`define CAG_VEC_HI 14'h0000
`define CAG_VEC_LO 2'h0
`define CAG_BIT_ONE 8'h01
`endif

//--- rtl/cag_pkg.sv
// types for the address generator and processing-state control
package cag_pkg;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cag_size_e;
    typedef enum logic [3:0] {
        AM_DISP16, AM_DISP32, AM_POSTINC, AM_PREDEC,
        AM_ABS8, AM_ABS16, AM_ABS24, AM_ABS32,
        AM_IMM8, AM_IMM16, AM_IMM32,
        AM_PCREL8, AM_PCREL16, AM_MEMIND
    } cag_mode_e;
    typedef enum logic [2:0] {
        OP_EA, OP_BIT, OP_BRANCH, OP_JUMP, OP_TRAP, OP_SLEEP
    } cag_op_e;
    typedef enum logic [2:0] {
        BIT_SET, BIT_CLR, BIT_INV, BIT_STORE, BIT_ISTORE
    } cag_bitop_e;
    typedef enum logic [2:0] {
        ST_RESET, ST_VEC_RD, ST_IDLE, ST_IND_RD,
        ST_BIT_RD, ST_BIT_WR, ST_BUS_REL, ST_STOP
    } cag_state_e;
endpackage

//--- rtl/cag_ea_calc.sv
// combinational effective-address calculation for all memory modes
`timescale 1ns/10ps
`default_nettype none
`include "cag_cfg.svh"
module cag_ea_calc import cag_pkg::*; (
    // operation fields
    input wire cag_mode_e mode,
    input wire cag_size_e size,
    input wire logic [31:0] areg,
    input wire logic [31:0] ext,
    input wire logic [23:0] next_pc,
    // results
    output logic [23:0] ea,
    output logic [31:0] wb,
    output logic wb_en,
    output logic [31:0] imm
);
    // access size to register step
    function automatic logic [31:0] cag_step(input cag_size_e s);
        unique case (s)
            SZ_BYTE: cag_step = `CAG_STEP_BYTE;
            SZ_WORD: cag_step = `CAG_STEP_WORD;
            default: cag_step = `CAG_STEP_LONG;
        endcase
    endfunction

    logic [31:0] sx8;
    logic [31:0] sx16;
    logic [31:0] sum;

    assign sx8 = {{24{ext[7]}}, ext[7:0]};
    assign sx16 = {{16{ext[15]}}, ext[15:0]};

    // only the low 24 bits reach the bus, so sums wrap on their own
    always_comb begin
        ea = areg[23:0];
        wb = areg;
        wb_en = 1'b0;
        imm = ext;
        sum = areg;
        unique case (mode)
            AM_DISP16: begin
                sum = areg + sx16;
                ea = sum[23:0];
            end
            AM_DISP32: begin
                sum = areg + ext;
                ea = sum[23:0];
            end
            AM_POSTINC: begin
                ea = areg[23:0];
                wb = areg + cag_step(size);
                wb_en = 1'b1;
            end
            AM_PREDEC: begin
                wb = areg - cag_step(size);
                ea = wb[23:0];
                wb_en = 1'b1;
            end
            AM_ABS8: ea = {`CAG_ABS8_FILL, ext[7:0]};
            AM_ABS16: ea = sx16[23:0];
            AM_ABS24: ea = ext[23:0];
            AM_ABS32: ea = ext[23:0];
            AM_IMM8: imm = {24'h000000, ext[7:0]};
            AM_IMM16: imm = {16'h0000, ext[15:0]};
            AM_IMM32: imm = ext;
            AM_PCREL8: begin
                sum = {8'h00, next_pc} + sx8;
                ea = sum[23:0];
            end
            AM_PCREL16: begin
                sum = {8'h00, next_pc} + sx16;
                ea = sum[23:0];
            end
            AM_MEMIND: ea = {`CAG_IND_HI, ext[7:0]};
            default: ea = areg[23:0];
        endcase
    end
endmodule
`default_nettype wire

//--- rtl/cag_top.sv
// processing-state control with address generation and memory sequencing
`timescale 1ns/10ps
`default_nettype none
`include "cag_cfg.svh"
module cag_top import cag_pkg::*; (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // reset and power sources
    input wire logic WDT_OVF,
    input wire logic HW_STBY,
    // exception request and mask control
    input wire logic EXC_REQ,
    input wire logic [7:0] EXC_VEC,
    input wire logic IMASK_CLR,
    // command, held until DONE
    input wire logic CMD_VALID,
    input wire cag_op_e CMD_OP,
    input wire cag_mode_e CMD_MODE,
    input wire cag_size_e CMD_SIZE,
    input wire logic [31:0] CMD_AREG,
    input wire logic [31:0] CMD_EXT,
    input wire logic [23:0] CMD_NEXT_PC,
    input wire cag_bitop_e CMD_BITOP,
    input wire logic [2:0] CMD_BITNUM,
    input wire logic [1:0] CMD_TRAPNUM,
    input wire logic CMD_CFLAG,
    // results
    output logic DONE,
    output logic [23:0] EA_ADDR,
    output logic [31:0] IMM_DATA,
    output logic [31:0] REG_WB,
    output logic REG_WB_EN,
    output logic [23:0] PC,
    // memory bus
    output logic MEM_REQ,
    output logic MEM_WE,
    output cag_size_e MEM_SIZE,
    output logic [23:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    input wire logic [31:0] MEM_RDATA,
    input wire logic MEM_ACK,
    // bus arbitration
    input wire logic BREQ,
    output logic BACK,
    // status
    output cag_state_e PROC_STATE,
    output logic INT_MASK
);
    // bit zero cleared for wide accesses and branch targets
    function automatic logic [23:0] cag_align(input logic [23:0] a,
                                              input logic en);
        cag_align = en ? (a & `CAG_ALIGN_MASK) : a;
    endfunction

    // vector number to table address, four bytes per entry
    function automatic logic [23:0] cag_vec_addr(input logic [7:0] v);
        cag_vec_addr = {`CAG_VEC_HI, v, `CAG_VEC_LO};
    endfunction

    // read-modify of one byte for the bit operations
    function automatic logic [7:0] cag_bit_mod(input logic [7:0] d,
                                               input cag_bitop_e op,
                                               input logic [2:0] n,
                                               input logic c);
        logic [7:0] m;
        m = `CAG_BIT_ONE << n;
        unique case (op)
            BIT_SET: cag_bit_mod = d | m;
            BIT_CLR: cag_bit_mod = d & ~m;
            BIT_INV: cag_bit_mod = d ^ m;
            BIT_STORE: cag_bit_mod = c ? (d | m) : (d & ~m);
            BIT_ISTORE: cag_bit_mod = c ? (d & ~m) : (d | m);
            default: cag_bit_mod = d;
        endcase
    endfunction

    cag_state_e state_r;
    cag_state_e state_nxt;
    logic [23:0] ea_raw;
    logic [31:0] wb_val;
    logic wb_en;
    logic [31:0] imm_val;
    logic [23:0] ea_al;
    logic wide;
    logic in_idle;
    logic free;
    logic take;
    logic exc_take;
    logic trap_take;
    logic vec_go;
    logic ind_take;
    logic bit_take;
    logic mem_done;
    logic [7:0] trap_vec;
    logic [23:0] vec_addr;

    cag_ea_calc u_ea (
        .mode(CMD_MODE),
        .size(CMD_SIZE),
        .areg(CMD_AREG),
        .ext(CMD_EXT),
        .next_pc(CMD_NEXT_PC),
        .ea(ea_raw),
        .wb(wb_val),
        .wb_en(wb_en),
        .imm(imm_val)
    );

    // branch and jump targets are always aligned, data only when wide
    assign wide = (CMD_SIZE != SZ_BYTE) || (CMD_OP == OP_BRANCH) ||
                  (CMD_OP == OP_JUMP);
    assign ea_al = cag_align(ea_raw, wide);

    // event decode in the idle state, highest priority first
    assign in_idle = (state_r == ST_IDLE);
    assign free = in_idle && !HW_STBY && !BREQ;
    assign exc_take = free && EXC_REQ;
    // done guard stops a held command from running twice
    assign take = free && !EXC_REQ && CMD_VALID && !DONE;
    assign trap_take = take && (CMD_OP == OP_TRAP);
    assign vec_go = exc_take || trap_take;
    assign ind_take = take && (CMD_OP == OP_JUMP) &&
                      (CMD_MODE == AM_MEMIND);
    assign bit_take = take && (CMD_OP == OP_BIT);
    assign mem_done = MEM_REQ && MEM_ACK;
    assign trap_vec = `CAG_TRAP_VEC_BASE + {6'h00, CMD_TRAPNUM};
    assign vec_addr = cag_vec_addr(exc_take ? EXC_VEC : trap_vec);

    // next processing state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RESET: state_nxt = ST_VEC_RD;
            ST_VEC_RD: if (mem_done) state_nxt = ST_IDLE;
            ST_IDLE: begin
                if (HW_STBY) begin
                    state_nxt = ST_STOP;
                end else if (BREQ) begin
                    state_nxt = ST_BUS_REL;
                end else if (vec_go) begin
                    state_nxt = ST_VEC_RD;
                end else if (ind_take) begin
                    state_nxt = ST_IND_RD;
                end else if (bit_take) begin
                    state_nxt = ST_BIT_RD;
                end else if (take && CMD_OP == OP_SLEEP) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_IND_RD: if (mem_done) state_nxt = ST_IDLE;
            ST_BIT_RD: if (mem_done) state_nxt = ST_BIT_WR;
            ST_BIT_WR: if (mem_done) state_nxt = ST_IDLE;
            ST_BUS_REL: if (!BREQ) state_nxt = ST_IDLE;
            ST_STOP: state_nxt = ST_STOP;
        endcase
    end

    // state register; watchdog overflow restarts like the pin
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_RESET;
        end else if (WDT_OVF) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign PROC_STATE = state_r;

    // memory port; a request stands until acknowledged or cleared by watchdog overflow
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_SIZE <= SZ_LONG;
            MEM_ADDR <= 24'h000000;
            MEM_WDATA <= 8'h00;
        end else if (WDT_OVF) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
        end else if (state_r == ST_RESET) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_SIZE <= SZ_LONG;
            MEM_ADDR <= cag_vec_addr(`CAG_RESET_VEC);
        end else if (vec_go && state_nxt == ST_VEC_RD) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_SIZE <= SZ_LONG;
            MEM_ADDR <= vec_addr;
        end else if (state_nxt == ST_IND_RD && in_idle) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_SIZE <= SZ_LONG;
            MEM_ADDR <= cag_align(ea_raw, 1'b1);
        end else if (state_nxt == ST_BIT_RD && in_idle) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_SIZE <= SZ_BYTE;
            MEM_ADDR <= ea_raw;
        end else if (state_r == ST_BIT_RD && mem_done) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b1;
            MEM_WDATA <= cag_bit_mod(MEM_RDATA[7:0], CMD_BITOP,
                                     CMD_BITNUM, CMD_CFLAG);
        end else if (mem_done) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
        end
    end

    // program counter from vectors, branches and jumps
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PC <= 24'h000000;
        end else if (mem_done && state_r == ST_VEC_RD) begin
            PC <= cag_align(MEM_RDATA[23:0], 1'b1);
        end else if (mem_done && state_r == ST_IND_RD) begin
            // top byte of the fetched longword is taken as zero
            PC <= cag_align(MEM_RDATA[23:0], 1'b1);
        end else if (take && !ind_take &&
                     (CMD_OP == OP_BRANCH || CMD_OP == OP_JUMP)) begin
            PC <= ea_al;
        end
    end

    // completion strobe and computed results
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            DONE <= 1'b0;
            EA_ADDR <= 24'h000000;
            IMM_DATA <= 32'h00000000;
            REG_WB <= 32'h00000000;
            REG_WB_EN <= 1'b0;
        end else begin
            DONE <= 1'b0;
            REG_WB_EN <= 1'b0;
            if (take && (CMD_OP == OP_EA || CMD_OP == OP_BRANCH ||
                         (CMD_OP == OP_JUMP && !ind_take))) begin
                DONE <= 1'b1;
                EA_ADDR <= ea_al;
                IMM_DATA <= imm_val;
                REG_WB <= wb_val;
                REG_WB_EN <= wb_en && (CMD_OP == OP_EA);
            end else if (bit_take) begin
                EA_ADDR <= ea_raw;
                REG_WB <= wb_val;
            end else if (mem_done && (state_r == ST_IND_RD ||
                                      state_r == ST_BIT_WR)) begin
                DONE <= 1'b1;
                REG_WB_EN <= wb_en && (state_r == ST_BIT_WR);
            end else if (mem_done && state_r == ST_VEC_RD) begin
                DONE <= 1'b1;
            end
        end
    end

    // interrupt mask: set by reset and every exception entry
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            INT_MASK <= 1'b1;
        end else if (WDT_OVF || vec_go || state_r == ST_RESET) begin
            INT_MASK <= 1'b1;
        end else if (IMASK_CLR) begin
            INT_MASK <= 1'b0;
        end
    end

    // bus grant while released; cpu makes no request meanwhile
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            BACK <= 1'b0;
        end else begin
            BACK <= (state_nxt == ST_BUS_REL) && !WDT_OVF;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_bit_read;
        MEM_REQ && !MEM_WE && MEM_ACK && state_r == ST_BIT_RD;
    endsequence
    sequence s_bit_write(logic [23:0] a);
        MEM_REQ && MEM_WE && MEM_SIZE == SZ_BYTE && MEM_ADDR == a;
    endsequence

    property p_reset_vec;
        state_r == ST_RESET && !WDT_OVF |=>
            state_r == ST_VEC_RD && MEM_REQ && MEM_ADDR == 24'h000000;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset vector fetch not started");

    property p_wdt;
        WDT_OVF |=> state_r == ST_RESET ##1 INT_MASK;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog overflow did not reset");

    property p_mask;
        state_r == ST_RESET || state_r == ST_VEC_RD |-> INT_MASK;
    endproperty
    a_mask: assert property (p_mask)
        else $error("interrupts unmasked during reset handling");

    property p_vec_branch;
        state_r == ST_VEC_RD && mem_done |=>
            PC == ($past(MEM_RDATA[23:0]) & 24'hFFFFFE) &&
            state_r == ST_IDLE;
    endproperty
    a_vec_branch: assert property (p_vec_branch)
        else $error("vector not loaded into program counter");

    property p_bus_rel;
        in_idle && BREQ && !WDT_OVF |=> BACK && !MEM_REQ
            ##0 (BACK throughout (BREQ [*1]));
    endproperty
    a_bus_rel: assert property (p_bus_rel)
        else $error("bus not released on request");

    property p_stop;
        state_r == ST_STOP && !WDT_OVF |=>
            state_r == ST_STOP && !MEM_REQ && !DONE;
    endproperty
    a_stop: assert property (p_stop)
        else $error("cpu active in program stop state");

    property p_bit_rmw;
        logic [23:0] a;
        (s_bit_read, a = MEM_ADDR) ##1 !WDT_OVF |-> s_bit_write(a);
    endproperty
    a_bit_rmw: assert property (p_bit_rmw)
        else $error("bit operation did not write the byte back");

    property p_abs8;
        take && CMD_OP == OP_EA && CMD_MODE == AM_ABS8 |=>
            EA_ADDR[23:8] == 16'hFFFF && DONE;
    endproperty
    a_abs8: assert property (p_abs8)
        else $error("short absolute address not in top page");

    property p_postinc;
        take && CMD_OP == OP_EA && CMD_MODE == AM_POSTINC &&
        CMD_SIZE == SZ_LONG |=>
            REG_WB == $past(CMD_AREG) + 32'h00000004 && REG_WB_EN &&
            EA_ADDR == ($past(CMD_AREG[23:0]) & 24'hFFFFFE);
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("post-increment result wrong");

    property p_branch_even;
        take && CMD_OP == OP_BRANCH |=> !PC[0] && DONE;
    endproperty
    a_branch_even: assert property (p_branch_even)
        else $error("branch target left odd");

    property p_ind_fetch;
        ind_take |=> MEM_REQ && !MEM_WE && MEM_SIZE == SZ_LONG &&
            MEM_ADDR == {16'h0000, $past(CMD_EXT[7:1]), 1'b0};
    endproperty
    a_ind_fetch: assert property (p_ind_fetch)
        else $error("indirect operand fetch not an even longword");
endmodule
`default_nettype wire

//--- tb/cag_mem_model.sv
// memory and bus partner model for the address generator bench
`timescale 1ns/10ps
`default_nettype none
module cag_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic [3:0] lat,
    // answer side
    output logic [31:0] mem_rdata,
    output var logic mem_ack,
    // write log for the bench
    output var logic [23:0] wr_addr,
    output var logic [7:0] wr_data,
    output var logic [7:0] wr_cnt
);
    logic [3:0] cnt_r;
    logic [31:0] last_r;
    logic [31:0] word;

    // content: odd low byte, nonzero top byte the core must drop
    assign word = {8'hC3, 16'h4321, mem_addr[7:0] | 8'h01};
    // released data lines show the inverse, not a stale copy
    assign mem_rdata = mem_ack ? word : ~last_r;

    // wait lat+1 cycles with the request up, then one ack cycle; count restarts per access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            mem_ack <= 1'b0;
            last_r <= 32'h0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            cnt_r <= 4'h0;
            last_r <= word;
        end else if (mem_req) begin
            if (cnt_r >= lat) begin
                mem_ack <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end

    // log completed writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr <= 24'h0;
            wr_data <= 8'h0;
            wr_cnt <= 8'h0;
        end else if (mem_ack && mem_req && mem_we) begin
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
            wr_cnt <= wr_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- tb/cag_top_tb.sv
// self-checking bench for the address generator and state control
`timescale 1ns/10ps
`default_nettype none
module cag_top_tb import cag_pkg::*;;
    logic MCLK = 0, RST_N = 1, WDT_OVF = 0, HW_STBY = 0, EXC_REQ = 0;
    logic IMASK_CLR = 0, CMD_VALID = 0, CMD_CFLAG = 0, BREQ = 0;
    logic [7:0] EXC_VEC = 8'h00;
    cag_op_e CMD_OP = OP_EA;
    cag_mode_e CMD_MODE = AM_DISP16;
    cag_size_e CMD_SIZE = SZ_BYTE;
    cag_bitop_e CMD_BITOP = BIT_SET;
    logic [31:0] CMD_AREG = 0, CMD_EXT = 0, IMM_DATA, REG_WB, MEM_RDATA;
    logic [23:0] CMD_NEXT_PC = 0, EA_ADDR, PC, MEM_ADDR, wr_addr;
    logic [2:0] CMD_BITNUM = 0;
    logic [1:0] CMD_TRAPNUM = 0;
    logic DONE, REG_WB_EN, MEM_REQ, MEM_WE, MEM_ACK, BACK, INT_MASK, wbs;
    logic [7:0] MEM_WDATA, wr_data, wr_cnt;
    logic [3:0] lat = 4'h0;
    cag_size_e MEM_SIZE;
    cag_state_e PROC_STATE;
    int n_fail = 0, checks = 0, n;

    always #50 MCLK = ~MCLK;

    cag_top cag_top_i (.*);
    cag_mem_model cag_mem_model_i (.clk(MCLK), .rst_n(RST_N),
        .mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_addr(MEM_ADDR),
        .mem_wdata(MEM_WDATA), .lat(lat), .mem_rdata(MEM_RDATA),
        .mem_ack(MEM_ACK), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_cnt(wr_cnt));

    task automatic end_of_test;
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // inputs always move 10 ns after the rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge MCLK);
        #10;
    endtask

    task automatic chk(input string w, input logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic st(input cag_state_e e);
        chk("state", {29'h0, e}, {29'h0, PROC_STATE});
    endtask

    // bounded wait; a missing pulse ends the run
    task automatic wait_done;
        int i;
        i = 0;
        do begin
            tick(1);
            i++;
        end while (DONE !== 1'b1 && i < 40);
        if (DONE !== 1'b1) begin
            chk("done", 32'h1, {31'h0, DONE});
            end_of_test();
        end
    endtask

    // fields held until done, valid dropped in the done cycle
    task automatic cmd(input cag_op_e op, cag_mode_e md, cag_size_e sz,
        logic [31:0] ar, logic [31:0] ex, logic [23:0] np);
        CMD_OP = op;
        CMD_MODE = md;
        CMD_SIZE = sz;
        CMD_AREG = ar;
        CMD_EXT = ex;
        CMD_NEXT_PC = np;
        CMD_VALID = 1'b1;
        wait_done();
        wbs = REG_WB_EN;
        CMD_VALID = 1'b0;
        tick(1);
        chk("done once", 32'h0, {31'h0, DONE});
    endtask

    task automatic ea(input cag_mode_e md, cag_size_e sz, logic [31:0] ar,
        logic [31:0] ex, logic [23:0] e, logic we, logic [31:0] wb);
        cmd(OP_EA, md, sz, ar, ex, 24'h0);
        chk("ea", {8'h0, e}, {8'h0, EA_ADDR});
        chk("wb_en", {31'h0, we}, {31'h0, wbs});
        if (we) chk("wb", wb, REG_WB);
    endtask

    task automatic imm(input cag_mode_e md, logic [31:0] e);
        cmd(OP_EA, md, SZ_LONG, 32'h0, 32'hFFFFFF80, 24'h0);
        chk("imm", e, IMM_DATA);
    endtask

    task automatic br(input cag_mode_e md, logic [31:0] ex, logic [23:0] np,
        logic [23:0] e);
        cmd(OP_BRANCH, md, SZ_WORD, 32'h0, ex, np);
        chk("branch pc", {8'h0, e}, {8'h0, PC});
    endtask

    // read, change one bit, write the byte back once
    task automatic bit_op(input cag_bitop_e b, logic [7:0] e);
        logic [7:0] c0;
        c0 = wr_cnt;
        CMD_BITOP = b;
        cmd(OP_BIT, AM_ABS8, SZ_BYTE, 32'h0, 32'h10, 24'h0);
        chk("bit addr", 32'hFFFF10, {8'h0, wr_addr});
        chk("bit data", {24'h0, e}, {24'h0, wr_data});
        chk("bit writes", {24'h0, c0 + 8'h01}, {24'h0, wr_cnt});
    endtask

    task automatic unmask;
        IMASK_CLR = 1'b1;
        tick(1);
        IMASK_CLR = 1'b0;
        tick(1);
        chk("unmask", 32'h0, {31'h0, INT_MASK});
    endtask

    // asynchronous entry, vector fetch only after release
    task automatic do_reset;
        RST_N = 1'b0;
        #5;
        st(ST_RESET);
        chk("reset mask", 32'h1, {31'h0, INT_MASK});
        tick(10);
        chk("reset req", 32'h0, {31'h0, MEM_REQ});
        RST_N = 1'b1;
        wait_done();
        chk("reset pc", 32'h432100, {8'h0, PC});
        tick(1);
    endtask

    initial begin
        #10;
        do_reset();
        ea(AM_DISP16, SZ_WORD, 32'h1000, 32'hFFFE, 24'hFFE, 0, 0);
        ea(AM_DISP32, SZ_LONG, 32'hFFFFF0, 32'h20, 24'h10, 0, 0);
        ea(AM_DISP16, SZ_WORD, 32'h1001, 32'h0, 24'h1000, 0, 0);
        ea(AM_POSTINC, SZ_BYTE, 32'h123, 0, 24'h123, 1, 32'h124);
        ea(AM_POSTINC, SZ_WORD, 32'h200, 0, 24'h200, 1, 32'h202);
        ea(AM_POSTINC, SZ_LONG, 32'h300, 0, 24'h300, 1, 32'h304);
        ea(AM_PREDEC, SZ_BYTE, 32'h123, 0, 24'h122, 1, 32'h122);
        ea(AM_PREDEC, SZ_WORD, 32'h200, 0, 24'h1FE, 1, 32'h1FE);
        ea(AM_PREDEC, SZ_LONG, 32'h300, 0, 24'h2FC, 1, 32'h2FC);
        ea(AM_ABS8, SZ_BYTE, 0, 32'h34, 24'hFFFF34, 0, 0);
        ea(AM_ABS16, SZ_BYTE, 0, 32'h8000, 24'hFF8000, 0, 0);
        ea(AM_ABS16, SZ_BYTE, 0, 32'h7FFF, 24'h7FFF, 0, 0);
        ea(AM_ABS32, SZ_BYTE, 0, 32'hABCDEF, 24'hABCDEF, 0, 0);
        ea(AM_ABS24, SZ_BYTE, 0, 32'hFF123456, 24'h123456, 0, 0);
        imm(AM_IMM8, 32'h80);
        imm(AM_IMM16, 32'hFF80);
        imm(AM_IMM32, 32'hFFFFFF80);
        br(AM_PCREL8, 32'h80, 24'h1000, 24'hF80);
        br(AM_PCREL16, 32'h7FFE, 24'hFFF000, 24'h6FFE);
        br(AM_PCREL8, 32'h3, 24'h1000, 24'h1002);
        lat = 4'h2;
        CMD_BITNUM = 3'h1;
        CMD_CFLAG = 1'b1;
        bit_op(BIT_SET, 8'h13);
        bit_op(BIT_CLR, 8'h11);
        bit_op(BIT_INV, 8'h13);
        bit_op(BIT_STORE, 8'h13);
        bit_op(BIT_ISTORE, 8'h11);
        lat = 4'h3;
        unmask();
        for (n = 0; n < 4; n++) begin
            CMD_TRAPNUM = n[1:0];
            cmd(OP_TRAP, AM_IMM8, SZ_LONG, 32'h0, 32'h0, 24'h0);
            chk("trap pc", {16'h43, 8'h21, 8'(32 + 4 * n)}, {8'h0, PC});
            chk("trap mask", 32'h1, {31'h0, INT_MASK});
        end
        lat = 4'h0;
        unmask();
        EXC_VEC = 8'h05;
        EXC_REQ = 1'b1;
        wait_done();
        EXC_REQ = 1'b0;
        tick(1);
        chk("exc pc", 32'h432114, {8'h0, PC});
        chk("exc mask", 32'h1, {31'h0, INT_MASK});
        cmd(OP_JUMP, AM_MEMIND, SZ_LONG, 0, 32'hFFFFFF81, 0);
        chk("jump pc", 32'h432180, {8'h0, PC});
        BREQ = 1'b1;
        tick(2);
        chk("grant", 32'h1, {31'h0, BACK});
        st(ST_BUS_REL);
        CMD_OP = OP_EA;
        CMD_MODE = AM_ABS8;
        CMD_EXT = 32'h20;
        CMD_VALID = 1'b1;
        tick(3);
        chk("halted", 32'h0, {31'h0, DONE});
        BREQ = 1'b0;
        wait_done();
        CMD_VALID = 1'b0;
        chk("regrant", 32'h0, {31'h0, BACK});
        chk("resume ea", 32'hFFFF20, {8'h0, EA_ADDR});
        tick(1);
        unmask();
        WDT_OVF = 1'b1;
        tick(1);
        WDT_OVF = 1'b0;
        st(ST_RESET);
        chk("wdt mask", 32'h1, {31'h0, INT_MASK});
        wait_done();
        chk("wdt pc", 32'h432100, {8'h0, PC});
        tick(1);
        CMD_OP = OP_SLEEP;
        CMD_VALID = 1'b1;
        tick(3);
        CMD_VALID = 1'b0;
        tick(10);
        st(ST_STOP);
        chk("stop req", 32'h0, {31'h0, MEM_REQ});
        do_reset();
        HW_STBY = 1'b1;
        tick(2);
        HW_STBY = 1'b0;
        tick(3);
        st(ST_STOP);
        do_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
